// ### bench/adc_chain_serial_ctrl_tb.sv
`timescale 1ns/1ps
module adc_chain_serial_ctrl_tb;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic rst_pin_n = 1'b0;
  logic dec_pin = 1'b0;
  logic sync_n = 1'b1;
  logic [31:0] res = 32'h0;
  logic res_v = 1'b0;
  logic settled = 1'b1;
  logic frame_in_n, din, ihc, ser_clk, fs_out_n, dout, pd, dec128, shold;
  logic ract, wstb;
  logic [15:0] waddr, wdata;
  int fails = 0;
  int n_checks = 0;
  always #4 clk_sys = ~clk_sys;
  adc_chain_serial_ctrl DUT (
    .clk_sys(clk_sys), .srst(srst), .ce(ce),
    .reset_powerdown_input_n(rst_pin_n), .decimation_select_pin(dec_pin),
    .sync_input_n(sync_n), .frame_sync_input_n(frame_in_n),
    .serial_data_input(din), .result_data(res), .result_valid(res_v),
    .filter_settled(settled), .internal_half_clock(ihc),
    .serial_clock_output(ser_clk), .frame_sync_output_n(fs_out_n),
    .serial_data_output(dout), .powerdown(pd), .decimation_128(dec128),
    .sync_hold(shold), .read_active(ract), .write_addr(waddr),
    .write_data(wdata), .write_strobe(wstb)
  );
  host_link_model host (
    .serial_clock_output(ser_clk), .frame_sync_input_n(frame_in_n),
    .serial_data_input(din)
  );
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // pin moves on falling master edges, away from the sampling edge
  task automatic t_reset;
    tick(20);
    srst = 1'b0;
    tick(4);
    check("pd held", pd, 1);
    @(negedge clk_sys) rst_pin_n = 1'b1;
    tick(2);
    check("pd early", pd, 1);
    tick(1);
    check("pd clear", pd, 0);
    @(negedge clk_sys) rst_pin_n = 1'b0;
    @(negedge clk_sys) rst_pin_n = 1'b1;
    tick(2);
    check("pd pulse", pd, 1);
    tick(3);
    check("pd out", pd, 0);
  endtask
  task automatic t_pins;
    logic b;
    time t;
    check("dec256", dec128, 0);
    dec_pin = 1'b1;
    tick(4);
    check("dec128", dec128, 1);
    for (int i = 0; i < 4; i++) begin
      b = ihc;
      tick(1);
      check("half clk", ihc, !b);
    end
    ce = 1'b0;
    b = ihc;
    tick(3);
    check("freeze", ihc, b);
    ce = 1'b1;
    @(posedge ser_clk);
    t = $time;
    @(posedge ser_clk);
    check("ser period", 32'($time - t), 64);
    tick(1);
    sync_n = 1'b0;
    tick(4);
    check("sync on", shold, 1);
    sync_n = 1'b1;
    tick(4);
    check("sync off", shold, 0);
  endtask
  task automatic t_read(input logic [31:0] w);
    logic [31:0] f;
    int n;
    res = w;
    res_v = 1'b1;
    tick(1);
    res_v = 1'b0;
    n = 0;
    while (fs_out_n !== 1'b0 && n < 4) begin
      @(negedge ser_clk);
      n++;
    end
    for (int i = 0; i < 32; i++) begin
      check("own bit", dout, w[31-i]);
      check("fs out low", fs_out_n, 0);
      @(negedge ser_clk);
    end
    for (int i = 0; i < 32; i++) begin
      f[31-i] = dout;
      check("fs out high", fs_out_n, 1);
      @(negedge ser_clk);
    end
    check("fwd ones", $countones(f), 1);
    n = 64;
    while (ract === 1'b1 && n < 300) begin
      @(negedge ser_clk);
      n++;
    end
    check("frame len", (n >= 127 && n <= 129), 1);
  endtask
  task automatic t_write(input logic [31:0] w, input int p);
    int n;
    fork
      host.write_frame(w, p);
      begin
        n = 0;
        while (wstb !== 1'b1 && n < 600) begin
          tick(1);
          n++;
        end
        check("waddr", waddr, w[31:16]);
        check("wdata", wdata, w[15:0]);
        @(negedge ser_clk);
        if (p > 32) check("pass", dout, 1);
      end
    join
  endtask
  // unsettled result is dropped; a write then cuts a running read short
  task automatic t_refuse_abort;
    settled = 1'b0;
    res_v = 1'b1;
    tick(1);
    res_v = 1'b0;
    tick(20);
    check("unsettled", ract, 0);
    settled = 1'b1;
    res_v = 1'b1;
    tick(1);
    res_v = 1'b0;
    // abort lands inside the own bits, while frame sync out is low
    repeat (10) @(negedge ser_clk);
    t_write(32'h00a5_5a3c, 32);
    check("abort", ract, 0);
    check("abort fs out", fs_out_n, 1);
  endtask
  initial begin
    t_reset;
    t_pins;
    t_read(32'hc3a5_0f81);
    t_refuse_abort;
    t_write(32'h0c33_f00f, 40);
    end_of_test;
  end
  initial begin
    #400000;
    fails++;
    end_of_test;
  end
endmodule

// ### bench/host_link_model.sv
`timescale 1ns/1ps
module host_link_model (
  input wire logic serial_clock_output,
  output logic frame_sync_input_n,
  output logic serial_data_input
);
  // one-hot downstream result keeps forwarding alignment visible
  logic [31:0] down_q = 32'h0000_0001;
  logic busy_q = 1'b0;
  initial begin
    frame_sync_input_n = 1'b1;
    serial_data_input = 1'b0;
  end
  always @(posedge serial_clock_output) begin
    if (!busy_q) begin
      #1 serial_data_input = down_q[31];
      down_q = {down_q[30:0], down_q[31]};
    end
  end
  // periods over 32 stand for further parts; their bits are all ones
  task automatic write_frame(input logic [31:0] w, input int periods);
    int n;
    n = (periods > 32) ? periods : 32;
    busy_q = 1'b1;
    @(posedge serial_clock_output);
    #1 frame_sync_input_n = 1'b0;
    for (int i = 1; i <= n; i++) begin
      @(posedge serial_clock_output);
      #1 serial_data_input = (i <= 32) ? w[32-i] : 1'b1;
      if (i == periods) frame_sync_input_n = 1'b1;
    end
    busy_q = 1'b0;
  endtask
endmodule

// ### src/adc_chain_pkg.sv
package adc_chain_pkg;

  typedef enum logic [1:0] {
    RD_IDLE = 2'h0,
    RD_OWN = 2'h1,
    RD_FWD = 2'h3
  } rd_state_e;

  typedef enum logic [1:0] {
    WR_IDLE = 2'h0,
    WR_ARM = 2'h1,
    WR_SHIFT = 2'h3,
    WR_PASS = 2'h2
  } wr_state_e;

endpackage

// ### src/adc_chain_regs.svh
`ifndef ADC_CHAIN_REGS_SVH
`define ADC_CHAIN_REGS_SVH

// master clock and derived clocks
`define MCLK_PERIOD_NS 8
`define HALF_CLK_DIV 2
`define SER_CLK_PERIOD_NS 64
`define SER_CLK_HALF_TICKS \
  (`SER_CLK_PERIOD_NS / (`MCLK_PERIOD_NS * `HALF_CLK_DIV * 2))

// frame layout
`define RESULT_BITS 9'h020
`define WR_ADDR_BITS 16
`define WR_DATA_BITS 16
`define DECIM_128 9'h080
`define DECIM_256 9'h100

// pin synchroniser layout and reset levels
`define PIN_RST_POS 4
`define PIN_DEC_POS 3
`define PIN_SYNC_POS 2
`define PIN_FRAME_POS 1
`define PIN_DIN_POS 0
`define PIN_RST_VAL 5'h06

`endif

// ### src/adc_chain_serial_ctrl.sv
`timescale 1ns/1ps
`include "adc_chain_regs.svh"
module adc_chain_serial_ctrl (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  input wire logic reset_powerdown_input_n,
  input wire logic decimation_select_pin,
  input wire logic sync_input_n,
  input wire logic frame_sync_input_n,
  input wire logic serial_data_input,
  input wire logic [31:0] result_data,
  input wire logic result_valid,
  input wire logic filter_settled,
  output logic internal_half_clock,
  output logic serial_clock_output,
  output logic frame_sync_output_n,
  output logic serial_data_output,
  output logic powerdown,
  output logic decimation_128,
  output logic sync_hold,
  output logic read_active,
  output logic [15:0] write_addr,
  output logic [15:0] write_data,
  output logic write_strobe
);
  localparam logic [1:0] SER_CLK_LAST = 2'(`SER_CLK_HALF_TICKS - 1);
  localparam logic [8:0] OWN_LAST = `RESULT_BITS - 9'h001;
  localparam logic [5:0] WR_LAST = 6'(`RESULT_BITS - 9'h001);

  logic [4:0] pin_raw;
  logic [4:0] pin_s;
  logic rst_pin_s;
  logic dec_s;
  logic sync_n_s;
  logic frame_n_s;
  logic din_s;
  logic rst_int;

  assign pin_raw = {reset_powerdown_input_n, decimation_select_pin,
                    sync_input_n, frame_sync_input_n, serial_data_input};
  assign rst_pin_s = pin_s[`PIN_RST_POS];
  assign dec_s = pin_s[`PIN_DEC_POS];
  assign sync_n_s = pin_s[`PIN_SYNC_POS];
  assign frame_n_s = pin_s[`PIN_FRAME_POS];
  assign din_s = pin_s[`PIN_DIN_POS];

  pin_sync #(
    .W(5),
    .RST_VAL(`PIN_RST_VAL)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .ce(ce),
    .d(pin_raw),
    .q(pin_s)
  );

  // powered-down state is simply the logic held in reset
  assign rst_int = srst | ~rst_pin_s;

  // clocking and static pins
  logic half_clk_q, half_clk_d;
  logic ser_clk_q, ser_clk_d;
  logic [1:0] ser_cnt_q, ser_cnt_d;
  logic pd_q, pd_d;
  logic dec128_q, dec128_d;
  logic sync_hold_q, sync_hold_d;
  logic ser_rise_tick;
  logic ser_fall_tick;

  always_comb begin
    half_clk_d = ~half_clk_q;
    ser_clk_d = ser_clk_q;
    ser_cnt_d = ser_cnt_q;
    ser_rise_tick = 1'b0;
    ser_fall_tick = 1'b0;
    // serial clock advances only on internal clock rising ticks
    if (!half_clk_q) begin
      if (ser_cnt_q == SER_CLK_LAST) begin
        ser_cnt_d = 2'h0;
        ser_clk_d = ~ser_clk_q;
        ser_rise_tick = ~ser_clk_q;
        ser_fall_tick = ser_clk_q;
      end else begin
        ser_cnt_d = ser_cnt_q + 2'h1;
      end
    end
    pd_d = 1'b0;
    dec128_d = dec_s;
    sync_hold_d = ~sync_n_s;
  end

  always_ff @(posedge clk_sys) begin
    if (rst_int) begin
      half_clk_q <= 1'b0;
      ser_clk_q <= 1'b0;
      ser_cnt_q <= 2'h0;
      pd_q <= 1'b1;
      dec128_q <= 1'b0;
      sync_hold_q <= 1'b0;
    end else if (ce) begin
      half_clk_q <= half_clk_d;
      ser_clk_q <= ser_clk_d;
      ser_cnt_q <= ser_cnt_d;
      pd_q <= pd_d;
      dec128_q <= dec128_d;
      sync_hold_q <= sync_hold_d;
    end
  end

  // serial framing
  adc_chain_pkg::rd_state_e rd_state_q, rd_state_d;
  adc_chain_pkg::wr_state_e wr_state_q, wr_state_d;
  logic [8:0] rd_cnt_q, rd_cnt_d;
  logic [31:0] rd_shift_q, rd_shift_d;
  logic [5:0] wr_cnt_q, wr_cnt_d;
  logic [31:0] wr_shift_q, wr_shift_d;
  logic fs_out_q, fs_out_d;
  logic dout_q, dout_d;
  logic [15:0] waddr_q, waddr_d;
  logic [15:0] wdata_q, wdata_d;
  logic wstb_q, wstb_d;
  logic ract_q, ract_d;
  logic [8:0] fwd_last;
  logic frame_fall_seen;
  logic wr_busy;

  always_comb begin
    wr_state_d = wr_state_q;
    wr_cnt_d = wr_cnt_q;
    wr_shift_d = wr_shift_q;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    wstb_d = 1'b0;
    // frame sync in only looked at on serial clock falling ticks
    frame_fall_seen = ser_fall_tick & ~frame_n_s &
                      (wr_state_q == adc_chain_pkg::WR_IDLE);
    wr_busy = wr_state_q != adc_chain_pkg::WR_IDLE;
    unique case (wr_state_q)
      adc_chain_pkg::WR_IDLE: begin
        if (frame_fall_seen) begin
          wr_state_d = adc_chain_pkg::WR_ARM;
        end
      end
      adc_chain_pkg::WR_ARM: begin
        if (ser_fall_tick) begin
          wr_shift_d = {wr_shift_q[30:0], din_s};
          wr_cnt_d = 6'h1;
          wr_state_d = adc_chain_pkg::WR_SHIFT;
        end
      end
      adc_chain_pkg::WR_SHIFT: begin
        // further frame sync edges inside the frame are ignored
        if (ser_fall_tick) begin
          wr_shift_d = {wr_shift_q[30:0], din_s};
          if (wr_cnt_q == WR_LAST) begin
            waddr_d = wr_shift_d[31:16];
            wdata_d = wr_shift_d[15:0];
            wstb_d = 1'b1;
            wr_state_d = frame_n_s ? adc_chain_pkg::WR_IDLE :
                                     adc_chain_pkg::WR_PASS;
          end else begin
            wr_cnt_d = wr_cnt_q + 6'h1;
          end
        end
      end
      adc_chain_pkg::WR_PASS: begin
        if (ser_fall_tick && frame_n_s) begin
          wr_state_d = adc_chain_pkg::WR_IDLE;
        end
      end
    endcase

    fwd_last = (dec128_q ? `DECIM_128 : `DECIM_256) - `RESULT_BITS
               - 9'h001;
    rd_state_d = rd_state_q;
    rd_cnt_d = rd_cnt_q;
    rd_shift_d = rd_shift_q;
    fs_out_d = fs_out_q;
    dout_d = dout_q;
    if (frame_fall_seen) begin
      rd_state_d = adc_chain_pkg::RD_IDLE;
      fs_out_d = 1'b1;
    end else begin
      unique case (rd_state_q)
        adc_chain_pkg::RD_IDLE: begin
          if (ser_rise_tick) begin
            dout_d = 1'b0;
          end
          // a result offered while busy or unsettled is dropped
          if (result_valid && filter_settled && !sync_hold_q &&
              !wr_busy) begin
            rd_shift_d = result_data;
            rd_cnt_d = 9'h000;
            rd_state_d = adc_chain_pkg::RD_OWN;
          end
        end
        adc_chain_pkg::RD_OWN: begin
          if (ser_rise_tick) begin
            dout_d = rd_shift_q[31];
            rd_shift_d = {rd_shift_q[30:0], 1'b0};
            fs_out_d = 1'b0;
            if (rd_cnt_q == OWN_LAST) begin
              rd_cnt_d = 9'h000;
              rd_state_d = adc_chain_pkg::RD_FWD;
            end else begin
              rd_cnt_d = rd_cnt_q + 9'h001;
            end
          end
        end
        adc_chain_pkg::RD_FWD: begin
          if (ser_rise_tick) begin
            dout_d = din_s;
            fs_out_d = 1'b1;
            if (rd_cnt_q == fwd_last) begin
              rd_state_d = adc_chain_pkg::RD_IDLE;
            end else begin
              rd_cnt_d = rd_cnt_q + 9'h001;
            end
          end
        end
        default: begin
          rd_state_d = adc_chain_pkg::RD_IDLE;
          fs_out_d = 1'b1;
        end
      endcase
    end
    ract_d = rd_state_d != adc_chain_pkg::RD_IDLE;
    // pass-through owns the output once our own write slot is done
    if (wr_state_q == adc_chain_pkg::WR_PASS && ser_rise_tick) begin
      dout_d = din_s;
    end else if (wr_busy && ser_rise_tick) begin
      dout_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst_int) begin
      rd_state_q <= adc_chain_pkg::RD_IDLE;
      wr_state_q <= adc_chain_pkg::WR_IDLE;
      rd_cnt_q <= 9'h000;
      rd_shift_q <= 32'h0;
      wr_cnt_q <= 6'h0;
      wr_shift_q <= 32'h0;
      fs_out_q <= 1'b1;
      dout_q <= 1'b0;
      waddr_q <= 16'h0;
      wdata_q <= 16'h0;
      wstb_q <= 1'b0;
      ract_q <= 1'b0;
    end else if (ce) begin
      rd_state_q <= rd_state_d;
      wr_state_q <= wr_state_d;
      rd_cnt_q <= rd_cnt_d;
      rd_shift_q <= rd_shift_d;
      wr_cnt_q <= wr_cnt_d;
      wr_shift_q <= wr_shift_d;
      fs_out_q <= fs_out_d;
      dout_q <= dout_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      wstb_q <= wstb_d;
      ract_q <= ract_d;
    end
  end

  assign internal_half_clock = half_clk_q;
  assign serial_clock_output = ser_clk_q;
  assign frame_sync_output_n = fs_out_q;
  assign serial_data_output = dout_q;
  assign powerdown = pd_q;
  assign decimation_128 = dec128_q;
  assign sync_hold = sync_hold_q;
  assign read_active = ract_q;
  assign write_addr = waddr_q;
  assign write_data = wdata_q;
  assign write_strobe = wstb_q;

  // checking helpers
  logic [8:0] low_cnt_q;
  logic msb_q;
  always_ff @(posedge clk_sys) begin
    if (rst_int) begin
      low_cnt_q <= 9'h000;
      msb_q <= 1'b0;
    end else if (ce) begin
      low_cnt_q <= fs_out_q ? 9'h000 : low_cnt_q + 9'h001;
      if (rd_state_q == adc_chain_pkg::RD_IDLE &&
          rd_state_d == adc_chain_pkg::RD_OWN) begin
        msb_q <= result_data[31];
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst_int || !ce);

  pd_hold_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    !rst_pin_s |=> pd_q && fs_out_q && rd_state_q == adc_chain_pkg::RD_IDLE)
    else $error("not held in power-down");
  pd_release_a: assert property (
    @(posedge clk_sys) disable iff (srst)
    rst_pin_s && ce |=> !pd_q)
    else $error("power-down not left");
  half_clk_toggle_a: assert property (
    ##1 ce |=> half_clk_q != $past(half_clk_q))
    else $error("internal clock not halving");
  dec_follow_a: assert property (
    ce |=> dec128_q == $past(dec_s))
    else $error("decimation select not followed");
  fs_width_a: assert property (
    $rose(fs_out_q) && rd_state_q == adc_chain_pkg::RD_FWD |->
    low_cnt_q == 9'h100)
    else $error("frame sync low width wrong");
  msb_first_a: assert property (
    $fell(fs_out_q) |-> dout_q == msb_q)
    else $error("first bit is not msb");
  settled_gate_a: assert property (
    rd_state_q == adc_chain_pkg::RD_IDLE && !filter_settled |=>
    rd_state_q == adc_chain_pkg::RD_IDLE)
    else $error("read began unsettled");
  fsi_abort_a: assert property (
    frame_fall_seen |=> rd_state_q == adc_chain_pkg::RD_IDLE && fs_out_q)
    else $error("read not aborted by write");
  // 32 falling ticks of 8 cycles, strobe registered one cycle later
  write_len_a: assert property (
    frame_fall_seen |-> ##257 wstb_q)
    else $error("write word not after 32 bits");
  pass_thru_a: assert property (
    wr_state_q == adc_chain_pkg::WR_PASS && ser_rise_tick |=>
    dout_q == $past(din_s))
    else $error("serial input not passed through");
  fwd_path_a: assert property (
    rd_state_q == adc_chain_pkg::RD_FWD && ser_rise_tick &&
    !frame_fall_seen && !wr_busy |=> dout_q == $past(din_s))
    else $error("downstream bit not forwarded");
endmodule

// ### src/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_d;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // first stage feeds only the second
      always_comb begin
        meta_d[i] = d[i];
        sync_d[i] = meta_q[i];
      end
      always_ff @(posedge clk_sys) begin
        if (srst) begin
          meta_q[i] <= RST_VAL[i];
          q[i] <= RST_VAL[i];
        end else if (ce) begin
          meta_q[i] <= meta_d[i];
          q[i] <= sync_d[i];
        end
      end
    end
  endgenerate
endmodule
